// ==== rtl/tmc_pkg.sv ====
// types shared by the timer/counter modules
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_MODE_TIMER = 2'b00,
        TMC_MODE_WINDOW = 2'b01,
        TMC_MODE_PULSE = 2'b10,
        TMC_MODE_PPG = 2'b11
    } tmc_mode_type;

    typedef enum logic [1:0] {
        TMC_START_STOP = 2'b00,
        TMC_START_COMMAND = 2'b01,
        TMC_START_RISING = 2'b10,
        TMC_START_FALLING = 2'b11
    } tmc_start_type;

    typedef enum logic [1:0] {
        TMC_CLK_SLOW = 2'b00,
        TMC_CLK_MID = 2'b01,
        TMC_CLK_FAST = 2'b10,
        TMC_CLK_EXT = 2'b11
    } tmc_clk_type;

endpackage : tmc_pkg

// ==== rtl/tmc_prescaler.sv ====
// source clock prescaler: divides the fast clock and picks the counting tick
`timescale 1ns/1ps
`include "tmc_regs.svh"

module tmc_prescaler (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // clock sources
    input wire logic fs_tick,
    input wire logic pin_rise,
    // selection
    input wire logic divider_source_select,
    input wire logic sleep_mode,
    input wire tmc_pkg::tmc_clk_type source_clock_select,
    // selected tick
    output logic source_tick
);
    import tmc_pkg::*;

    logic [`TMC_DIV_WIDTH-1:0] div_reg;
    logic [`TMC_DIV_WIDTH-1:0] div_next;
    logic [2:0] fs_div_reg;
    logic [2:0] fs_div_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        div_next = div_reg + `TMC_DIV_WIDTH'h001;
        fs_div_next = fs_tick ? fs_div_reg + 3'h1 : fs_div_reg;
        tick_next = 1'b0;
        unique case (source_clock_select)
            TMC_CLK_SLOW: begin
                if (divider_source_select || sleep_mode) begin
                    tick_next = fs_tick && (fs_div_reg == `TMC_TAP_FS3);
                end else begin
                    tick_next = (div_reg & `TMC_TAP_FC11) == `TMC_TAP_FC11;
                end
            end
            // the fast clock is halted in sleep, so these taps give no tick there
            TMC_CLK_MID: tick_next = !sleep_mode && ((div_reg & `TMC_TAP_FC7) == `TMC_TAP_FC7);
            TMC_CLK_FAST: tick_next = !sleep_mode && ((div_reg & `TMC_TAP_FC3) == `TMC_TAP_FC3);
            TMC_CLK_EXT: tick_next = pin_rise;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= `TMC_DIV_WIDTH'h000;
            fs_div_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            fs_div_reg <= fs_div_next;
            tick_reg <= tick_next;
        end
    end

    assign source_tick = tick_reg;

endmodule : tmc_prescaler

// ==== rtl/tmc_regs.svh ====
// register indices, field positions, reset values and divider taps of the timer/counter
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// register indices; the byte address is four times the index
`define TMC_IDX_COMPARE_A_LOW 8'h10
`define TMC_IDX_COMPARE_A_HIGH 8'h11
`define TMC_IDX_CAPTURE_B_LOW 8'h12
`define TMC_IDX_CAPTURE_B_HIGH 8'h13
`define TMC_IDX_TIMER_CONTROL 8'h26
`define TMC_IDX_CLOCK_CONFIG 8'h28
`define TMC_IDX_COUNTER_VALUE 8'h29

// timer_control field positions
`define TMC_CTRL_TFF_BIT 7
`define TMC_CTRL_ACAP_BIT 6
`define TMC_CTRL_START_MSB 5
`define TMC_CTRL_START_LSB 4
`define TMC_CTRL_CLK_MSB 3
`define TMC_CTRL_CLK_LSB 2
`define TMC_CTRL_MODE_MSB 1
`define TMC_CTRL_MODE_LSB 0

// clock_config field position
`define TMC_CFG_DIVSRC_BIT 0

// reset values
`define TMC_RST_TIMER_REG 16'hFFFF
`define TMC_RST_CONTROL 8'h00
`define TMC_RST_COUNTER 16'h0000

// divider taps: a tick every 2^n cycles of the fast clock, or every 2^3 low-frequency ticks for FS3
`define TMC_DIV_WIDTH 11
`define TMC_TAP_FC11 11'h7FF
`define TMC_TAP_FC7 11'h07F
`define TMC_TAP_FC3 11'h007
`define TMC_TAP_FS3 3'h7

`endif

// ==== rtl/tmc_timer.sv ====
// 16-bit up-counting timer/counter with AHB-Lite register slave
`timescale 1ns/1ps
`include "tmc_regs.svh"

module tmc_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // chip power state and clock sources
    input wire logic stop_mode_req,
    input wire logic sleep_mode,
    input wire logic fs_tick,
    // external pin
    input wire logic timer_input_pin,
    // events
    output logic timer_match_interrupt
);
    import tmc_pkg::*;

    // bus state
    logic wr_pend_reg;
    logic wr_pend_next;
    logic rd_pend_reg;
    logic rd_pend_next;
    logic rd_ready_reg;
    logic rd_ready_next;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic idx_ok_reg;
    logic idx_ok_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    // registers
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic divsrc_reg;
    logic divsrc_next;
    logic [15:0] a_shadow_reg;
    logic [15:0] a_shadow_next;
    logic [15:0] a_active_reg;
    logic [15:0] a_active_next;
    logic a_pending_reg;
    logic a_pending_next;
    logic [15:0] b_shadow_reg;
    logic [15:0] b_shadow_next;
    logic [15:0] b_reg;
    logic [15:0] b_next;
    logic b_pending_reg;
    logic b_pending_next;

    // counting state
    logic [15:0] counter_reg;
    logic [15:0] counter_next;
    logic pin_prev_reg;
    logic match_reg;
    logic match_next;

    logic addr_phase;
    logic wr_en;
    logic source_tick;
    logic pin_rise;
    logic pin_fall;
    logic count_en;
    logic capture_en;
    tmc_mode_type mode;
    tmc_start_type start;
    tmc_clk_type clk_sel;

    // word index from a byte address; unaligned or out-of-range gives not-ok
    function automatic logic index_ok(input logic [31:0] addr);
        index_ok = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h000000);
    endfunction : index_ok

    // replace the low or high byte of a 16-bit value
    function automatic logic [15:0] put_byte(input logic [15:0] value, input logic high,
                                             input logic [7:0] data);
        put_byte = high ? {data, value[7:0]} : {value[15:8], data};
    endfunction : put_byte

    assign mode = tmc_mode_type'(control_reg[`TMC_CTRL_MODE_MSB:`TMC_CTRL_MODE_LSB]);
    assign start = tmc_start_type'(control_reg[`TMC_CTRL_START_MSB:`TMC_CTRL_START_LSB]);
    assign clk_sel = tmc_clk_type'(control_reg[`TMC_CTRL_CLK_MSB:`TMC_CTRL_CLK_LSB]);

    assign pin_rise = timer_input_pin && !pin_prev_reg;
    assign pin_fall = !timer_input_pin && pin_prev_reg;

    tmc_prescaler u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .fs_tick(fs_tick),
        .pin_rise(pin_rise),
        .divider_source_select(divsrc_reg),
        .sleep_mode(sleep_mode),
        .source_clock_select(clk_sel),
        .source_tick(source_tick)
    );

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_en = wr_pend_reg;

    // ---------------- bus slave ----------------
    always_comb begin
        wr_pend_next = wr_pend_reg;
        rd_pend_next = rd_pend_reg;
        rd_ready_next = rd_ready_reg;
        idx_next = idx_reg;
        idx_ok_next = idx_ok_reg;
        hrdata_next = hrdata_reg;
        // reads take one wait state so the data is sampled after any write just before
        if (rd_pend_reg && !rd_ready_reg) begin
            rd_ready_next = 1'b1;
            hrdata_next = 32'h00000000;
            if (idx_ok_reg) begin
                unique case (idx_reg)
                    `TMC_IDX_COMPARE_A_LOW: hrdata_next = {24'h000000, a_shadow_reg[7:0]};
                    `TMC_IDX_COMPARE_A_HIGH: hrdata_next = {24'h000000, a_shadow_reg[15:8]};
                    `TMC_IDX_CAPTURE_B_LOW: hrdata_next = {24'h000000, b_reg[7:0]};
                    `TMC_IDX_CAPTURE_B_HIGH: hrdata_next = {24'h000000, b_reg[15:8]};
                    `TMC_IDX_TIMER_CONTROL: hrdata_next = {24'h000000, control_reg};
                    `TMC_IDX_CLOCK_CONFIG: hrdata_next = {31'h00000000, divsrc_reg};
                    `TMC_IDX_COUNTER_VALUE: hrdata_next = {16'h0000, counter_reg};
                    default: hrdata_next = 32'h00000000;
                endcase
            end
        end
        if (hready) begin
            wr_pend_next = 1'b0;
            rd_pend_next = 1'b0;
            rd_ready_next = 1'b0;
        end
        if (addr_phase) begin
            wr_pend_next = hwrite;
            rd_pend_next = !hwrite;
            idx_next = haddr[9:2];
            idx_ok_next = index_ok(haddr);
        end
    end

    assign hreadyout = !(rd_pend_reg && !rd_ready_reg);
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;

    // ---------------- registers and counter ----------------
    always_comb begin
        control_next = control_reg;
        divsrc_next = divsrc_reg;
        a_shadow_next = a_shadow_reg;
        a_active_next = a_active_reg;
        a_pending_next = a_pending_reg;
        b_shadow_next = b_shadow_reg;
        b_next = b_reg;
        b_pending_next = b_pending_reg;
        counter_next = counter_reg;
        match_next = 1'b0;
        count_en = 1'b0;
        capture_en = 1'b0;

        // buffered values move to the active side on a source tick
        if (source_tick && a_pending_reg) begin
            a_active_next = a_shadow_reg;
            a_pending_next = 1'b0;
        end
        if (source_tick && b_pending_reg) begin
            b_next = b_shadow_reg;
            b_pending_next = 1'b0;
        end

        // counting source per mode and start code
        unique case (mode)
            TMC_MODE_TIMER: begin
                if (start == TMC_START_COMMAND) begin
                    count_en = source_tick;
                end else if (start == TMC_START_RISING) begin
                    count_en = pin_rise;
                end else if (start == TMC_START_FALLING) begin
                    count_en = pin_fall;
                end
                capture_en = start != TMC_START_STOP;
            end
            TMC_MODE_WINDOW: begin
                // positive logic counts while the pin is high, negative while low
                if (start == TMC_START_RISING) begin
                    count_en = source_tick && timer_input_pin;
                end else if (start == TMC_START_FALLING) begin
                    count_en = source_tick && !timer_input_pin;
                end
                capture_en = start != TMC_START_STOP;
            end
            // pulse width and pulse output counting are not built; counter holds
            TMC_MODE_PULSE: capture_en = 1'b0;
            TMC_MODE_PPG: capture_en = 1'b0;
        endcase

        if (start == TMC_START_STOP) begin
            counter_next = `TMC_RST_COUNTER;
        end else if (count_en) begin
            if (counter_reg == a_active_reg) begin
                counter_next = `TMC_RST_COUNTER;
                match_next = 1'b1;
            end else begin
                counter_next = counter_reg + 16'h0001;
            end
        end

        if (capture_en && control_reg[`TMC_CTRL_ACAP_BIT] && source_tick) begin
            b_next = counter_reg;
        end

        // software writes; a high-byte write (to B only in PPG mode) arms the transfer and wins over the tick
        if (wr_en && idx_ok_reg) begin
            unique case (idx_reg)
                `TMC_IDX_COMPARE_A_LOW: begin
                    a_shadow_next = put_byte(a_shadow_reg, 1'b0, hwdata[7:0]);
                end
                `TMC_IDX_COMPARE_A_HIGH: begin
                    a_shadow_next = put_byte(a_shadow_reg, 1'b1, hwdata[7:0]);
                    a_pending_next = 1'b1;
                end
                `TMC_IDX_CAPTURE_B_LOW: begin
                    if (mode == TMC_MODE_PPG) begin
                        b_shadow_next = put_byte(b_shadow_reg, 1'b0, hwdata[7:0]);
                    end
                end
                `TMC_IDX_CAPTURE_B_HIGH: begin
                    if (mode == TMC_MODE_PPG) begin
                        b_shadow_next = put_byte(b_shadow_reg, 1'b1, hwdata[7:0]);
                        b_pending_next = 1'b1;
                    end
                end
                `TMC_IDX_TIMER_CONTROL: control_next = hwdata[7:0];
                `TMC_IDX_CLOCK_CONFIG: divsrc_next = hwdata[`TMC_CFG_DIVSRC_BIT];
                default: control_next = control_reg;
            endcase
        end

        // stop power mode overrides any start written in the same cycle
        if (stop_mode_req) begin
            control_next[`TMC_CTRL_START_MSB:`TMC_CTRL_START_LSB] = TMC_START_STOP;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_ready_reg <= 1'b0;
            idx_reg <= 8'h00;
            idx_ok_reg <= 1'b0;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            rd_ready_reg <= rd_ready_next;
            idx_reg <= idx_next;
            idx_ok_reg <= idx_ok_next;
            hrdata_reg <= hrdata_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= `TMC_RST_CONTROL;
            divsrc_reg <= 1'b0;
            a_shadow_reg <= `TMC_RST_TIMER_REG;
            a_active_reg <= `TMC_RST_TIMER_REG;
            a_pending_reg <= 1'b0;
            b_shadow_reg <= `TMC_RST_TIMER_REG;
            b_reg <= `TMC_RST_TIMER_REG;
            b_pending_reg <= 1'b0;
            counter_reg <= `TMC_RST_COUNTER;
            pin_prev_reg <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            control_reg <= control_next;
            divsrc_reg <= divsrc_next;
            a_shadow_reg <= a_shadow_next;
            a_active_reg <= a_active_next;
            a_pending_reg <= a_pending_next;
            b_shadow_reg <= b_shadow_next;
            b_reg <= b_next;
            b_pending_reg <= b_pending_next;
            counter_reg <= counter_next;
            pin_prev_reg <= timer_input_pin;
            match_reg <= match_next;
        end
    end

    assign timer_match_interrupt = match_reg;

endmodule : tmc_timer

// ==== tb/tb_tmc_timer.sv ====
// self-checking testbench of the timer/counter
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tb_tmc_timer;
    localparam logic [7:0] a_lo = `TMC_IDX_COMPARE_A_LOW;
    localparam logic [7:0] a_hi = `TMC_IDX_COMPARE_A_HIGH;
    localparam logic [7:0] b_lo = `TMC_IDX_CAPTURE_B_LOW;
    localparam logic [7:0] b_hi = `TMC_IDX_CAPTURE_B_HIGH;
    localparam logic [7:0] ctl = `TMC_IDX_TIMER_CONTROL;
    localparam logic [7:0] cfg = `TMC_IDX_CLOCK_CONFIG;
    localparam logic [7:0] cnt = `TMC_IDX_COUNTER_VALUE;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, irq;
    logic stop_mode_req = 1'b0, sleep_mode = 1'b0, fs_tick = 1'b0, pin = 1'b0;
    int num_errors = 0, n_checks = 0, cyc = 0, seed = 32'h7C42C166;
    // tick periods in hclk cycles for each source setting
    int clk_t[6] = '{2, 1, 0, 0, 0, 3};
    int dsrc_t[6] = '{0, 0, 0, 1, 0, 0};
    int slp_t[6] = '{0, 0, 0, 0, 1, 0};
    int per_t[6] = '{8, 128, 2048, 128, 128, 20};
    logic [31:0] d, a;
    // last control value written, so a stop can keep the other fields
    logic [7:0] ctl_sh = 8'h00;
    assign hready = hreadyout;
    tmc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stop_mode_req(stop_mode_req),
        .sleep_mode(sleep_mode), .fs_tick(fs_tick), .timer_input_pin(pin),
        .timer_match_interrupt(irq));
    initial begin
        forever #10 hclk = ~hclk;
    end
    // low-frequency clock every 16 cycles, pin rising edge every 20
    always @(posedge hclk) begin
        cyc = cyc + 1;
        fs_tick <= (cyc % 16 == 15);
        if (cyc % 10 == 9)
            pin <= ~pin;
        if (cyc == 60000) begin
            num_errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ad
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [31:0] ba, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= ba;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1 && ++k < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1 && ++k < 50);
        rd = hrdata;
        if (k >= 50)
            num_errors++;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        logic [31:0] x;
        bus(1'b1, ad(i), {24'h0, v}, x);
        if (i == ctl)
            ctl_sh = v;
    endtask : wr
    task automatic rdc(input logic [31:0] ba, input logic [31:0] exp, input string what);
        logic [31:0] x;
        bus(1'b0, ba, 32'h0, x);
        check(x, exp, what);
    endtask : rdc
    // waits for a match pulse; returns cycles waited
    task automatic wait_irq(input int lim, output int k);
        k = 0;
        do @(posedge hclk); while (irq !== 1'b1 && ++k < lim);
    endtask : wait_irq
    task automatic measure(input int exp);
        int k;
        wait_irq(20000, k);
        wait_irq(20000, k);
        // the edge that sees the pulse is not counted in k
        check(k + 1, exp, "match period");
    endtask : measure
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ad(a_lo), 32'hFF, "a low");
        rdc(ad(a_hi), 32'hFF, "a high");
        rdc(ad(b_hi), 32'hFF, "b high");
        rdc(ad(ctl), 32'h0, "control");
        rdc(ad(cfg), 32'h0, "clock config");
        rdc(32'h400, 32'h0, "unmapped");
        wr(cnt, 8'h55);
        rdc(ad(cnt), 32'h0, "counter");
        wr(b_lo, 8'h34);
        wr(b_hi, 8'h12);
        repeat (30) @(posedge hclk);
        rdc(ad(b_lo), 32'hFF, "b locked");
        wr(ctl, 8'h0B);
        wr(b_lo, 8'h34);
        wr(b_hi, 8'h12);
        repeat (30) @(posedge hclk);
        rdc(ad(b_lo), 32'h34, "b low");
        rdc(ad(b_hi), 32'h12, "b high");
        wr(ctl, 8'h5B);
        repeat (30) @(posedge hclk);
        rdc(ad(b_lo), 32'h34, "b no capture");
        rdc(ad(cnt), 32'h0, "no count");
        for (int i = 0; i < 6; i++) begin
            // stop first with the other fields kept, then change clock and mode
            wr(ctl, ctl_sh & 8'hCF);
            a = 2 + ($random(seed) & 3);
            wr(ctl, {4'h0, clk_t[i][1:0], 2'h0});
            wr(cfg, dsrc_t[i][7:0]);
            sleep_mode <= slp_t[i][0];
            wr(a_lo, a[7:0]);
            wr(a_hi, 8'h0);
            rdc(ad(ctl), {28'h0, clk_t[i][1:0], 2'h0}, "control");
            wr(ctl, {4'h1, clk_t[i][1:0], 2'h0});
            measure((a + 1) * per_t[i]);
        end
        // a lone low byte must leave the running compare value alone
        wr(a_lo, a[7:0] + 8'h3);
        measure((a + 1) * 20);
        rdc(ad(a_lo), a + 3, "a shadow");
        wr(ctl, 8'h5C);
        repeat (100) @(posedge hclk);
        bus(1'b0, ad(b_lo), 32'h0, d);
        check(d <= a, 1'b1, "capture range");
        stop_mode_req <= 1'b1;
        repeat (4) @(posedge hclk);
        stop_mode_req <= 1'b0;
        rdc(ad(ctl), 32'h4C, "forced stop");
        rdc(ad(cnt), 32'h0, "counter cleared");
        // restart after wake-up as an event counter on rising pin edges
        wr(ctl, 8'h2C);
        measure((a + 1) * 20);
        finish_test();
    end
endmodule : tb_tmc_timer

// ==== tb/tmc_timer_chk.sv ====
// assertion checker for the timer/counter, bound to its top module
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_timer_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // chip state, pins and events
    input wire logic stop_mode_req,
    input wire logic sleep_mode,
    input wire logic fs_tick,
    input wire logic timer_input_pin,
    input wire logic timer_match_interrupt
);
    logic take;
    logic wr_ctl_reg, wr_ctl_next;
    // start and mode fields as software or a stop request last left them
    logic [3:0] ctl_reg, ctl_next;
    assign take = hsel && hready && htrans[1];
    always_comb begin
        wr_ctl_next = take && hwrite && (haddr == {22'h0, `TMC_IDX_TIMER_CONTROL, 2'h0});
        ctl_next = ctl_reg;
        if (wr_ctl_reg)
            ctl_next = {hwdata[5:4], hwdata[1:0]};
        // the power-down request overrides a write in the same cycle
        if (stop_mode_req)
            ctl_next[3:2] = 2'h0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctl_reg <= 1'b0;
            ctl_reg <= 4'h0;
        end else begin
            wr_ctl_reg <= wr_ctl_next;
            ctl_reg <= ctl_next;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    okay_resp_a: assert property (hresp == 1'b0) else $error("slave answered with error");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write was stalled");
    rdata_stand_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read wait state");
    unmapped_zero_a: assert property (take && !hwrite && haddr[31:10] != 22'h0 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read returned data");
    irq_gap_a: assert property (timer_match_interrupt |=> !timer_match_interrupt [*7])
        else $error("match pulses too close together");
    stop_quiet_a: assert property (stop_mode_req [*3] |-> !timer_match_interrupt)
        else $error("match pulse while in stop power mode");
    idle_quiet_a: assert property (ctl_reg[3:2] == 2'h0 [*3] |-> !timer_match_interrupt)
        else $error("match pulse while stopped");
    mode_quiet_a: assert property (ctl_reg[1] [*3] |-> !timer_match_interrupt)
        else $error("match pulse in a non-counting mode");
    irq_c: cover property (timer_match_interrupt ##[8:200] timer_match_interrupt);
    rd_c: cover property (take && !hwrite);
    stop_c: cover property (stop_mode_req ##1 !stop_mode_req);
endmodule : tmc_timer_chk

bind tmc_timer tmc_timer_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stop_mode_req(stop_mode_req),
    .sleep_mode(sleep_mode), .fs_tick(fs_tick), .timer_input_pin(timer_input_pin),
    .timer_match_interrupt(timer_match_interrupt));
